// >>> hdl/mrr_device.sv
/*
 * release logic end: block timer, mains window check, release selection
 * and synchronism override gating.
 * assumes every link input is synchronous to clk and held by the controller.
 */
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module mrr_device #(
	parameter int TickCycles = mrr_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	mrr_link_if.dev link,
	output logic releaseOut,
	output logic closePermitOut,
	output logic blockRunning
);
	mrr_pkg::mrr_state_t state_q;
	mrr_pkg::mrr_state_t state_d;
	logic [24:0] tickCnt_q;
	logic secTick;
	logic [15:0] blkCnt_q;
	logic [15:0] blkCnt_d;
	logic [15:0] stbCnt_q;
	logic [15:0] stbCnt_d;
	logic windowOk_q;
	logic [mrr_pkg::NUM_PH-1:0] phOk;
	logic freqOk;
	logic trigAny;
	logic extUse;
	logic condOk;
	logic syncGate;
	logic live_bus_dead_line;
	logic dead_bus_live_line;
	logic dead_bus_dead_line;
	logic release_q;
	logic closePermit_q;
	logic block_q;

	// one-second time base
	assign secTick = (tickCnt_q == 25'(TickCycles - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_q <= 25'h0000000;
		end else if (ce) begin
			if (secTick) begin
				tickCnt_q <= 25'h0000000;
			end else begin
				tickCnt_q <= tickCnt_q + 25'h0000001;
			end
		end
	end

	// per-phase voltage window, instantaneous or averaged
	genvar ph;
	generate
		for (ph = 0; ph < mrr_pkg::NUM_PH; ph++) begin : g_phase
			logic [15:0] vSel;
			assign vSel = link.avgMethod ? link.vAvg[ph] : link.vInst[ph];
			assign phOk[ph] = (vSel >= link.vMin) && (vSel <= link.vMax);
		end
	endgenerate

	assign freqOk = (link.freq >= link.fMin) && (link.freq <= link.fMax);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			windowOk_q <= 1'b0;
		end else if (ce) begin
			windowOk_q <= freqOk && (&phOk);
		end
	end

	// all decoupling sources ORed into one start
	assign trigAny = (|link.decTrig) | link.diTrig | link.logicTrig | link.scadaTrig;

	// external signal only counts when its function is enabled
	assign extUse = link.extEnable & link.extRelease;

	always_comb begin
		unique case (mrr_pkg::mrr_cond_t'(link.relCond))
			mrr_pkg::COND_INTERNAL: condOk = windowOk_q;
			mrr_pkg::COND_EXTERNAL: condOk = extUse;
			mrr_pkg::COND_BOTH: condOk = windowOk_q & extUse;
			mrr_pkg::COND_NONE: condOk = 1'b0;
		endcase
	end

	// synchronism override states and bypass
	assign live_bus_dead_line = link.liveBus & ~link.liveLine;
	assign dead_bus_live_line = ~link.liveBus & link.liveLine;
	assign dead_bus_dead_line = ~link.liveBus & ~link.liveLine;
	assign syncGate = link.syncOk | link.syncBypass
		| (link.ovrEnable[0] & live_bus_dead_line) | (link.ovrEnable[1] & dead_bus_live_line)
		| (link.ovrEnable[2] & dead_bus_dead_line);

	always_comb begin
		state_d = state_q;
		blkCnt_d = blkCnt_q;
		stbCnt_d = stbCnt_q;
		if (link.pccTrip) begin
			// coupling-point trip: release or manual goes to manual, block and stable hold
			state_d = mrr_mrr_hold(state_q);
		end else begin
			unique case (state_q)
				mrr_pkg::ST_MANUAL: begin
					if (link.manualReset) begin
						state_d = mrr_pkg::ST_BLOCK;
						blkCnt_d = 16'h0000;
					end
				end
				mrr_pkg::ST_BLOCK: begin
					if (trigAny || !windowOk_q) begin
						blkCnt_d = 16'h0000;
					end else if (blkCnt_q >= link.tRelBlo) begin
						state_d = mrr_pkg::ST_STABLE;
						stbCnt_d = 16'h0000;
					end else if (secTick) begin
						blkCnt_d = blkCnt_q + 16'h0001;
					end
				end
				mrr_pkg::ST_STABLE: begin
					if (trigAny) begin
						state_d = mrr_pkg::ST_BLOCK;
						blkCnt_d = 16'h0000;
					end else if (!windowOk_q) begin
						stbCnt_d = 16'h0000;
					end else if (stbCnt_q >= link.tStable) begin
						if (condOk) begin
							state_d = mrr_pkg::ST_RELEASE;
						end
					end else if (secTick) begin
						stbCnt_d = stbCnt_q + 16'h0001;
					end
				end
				mrr_pkg::ST_RELEASE: begin
					if (trigAny) begin
						state_d = mrr_pkg::ST_BLOCK;
						blkCnt_d = 16'h0000;
					end else if (!condOk || !windowOk_q) begin
						state_d = mrr_pkg::ST_STABLE;
						stbCnt_d = 16'h0000;
					end
				end
			endcase
		end
	end

	function automatic mrr_pkg::mrr_state_t mrr_mrr_hold(input mrr_pkg::mrr_state_t s);
		mrr_mrr_hold = (s == mrr_pkg::ST_RELEASE || s == mrr_pkg::ST_MANUAL)
			? mrr_pkg::ST_MANUAL : s;
	endfunction : mrr_mrr_hold

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= mrr_pkg::ST_BLOCK;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			blkCnt_q <= 16'h0000;
		end else if (ce) begin
			blkCnt_q <= blkCnt_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stbCnt_q <= 16'h0000;
		end else if (ce) begin
			stbCnt_q <= stbCnt_d;
		end
	end

	// outputs follow the next state so a trigger drops release at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			release_q <= 1'b0;
		end else if (ce) begin
			release_q <= (state_d == mrr_pkg::ST_RELEASE);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			closePermit_q <= 1'b0;
		end else if (ce) begin
			closePermit_q <= (state_d == mrr_pkg::ST_RELEASE) && syncGate;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			block_q <= 1'b0;
		end else if (ce) begin
			block_q <= (state_d == mrr_pkg::ST_BLOCK);
		end
	end

	assign releaseOut = release_q;
	assign closePermitOut = closePermit_q;
	assign blockRunning = block_q;
	assign link.release_ = release_q;
	assign link.closePermit = closePermit_q;
	assign link.windowOk = windowOk_q;
	assign link.state = state_q;
endmodule : mrr_device

// >>> hdl/mrr_host.sv
/*
 * controller end: apb register file holding the settings, registers the
 * field inputs onto the link and reports the release end's status.
 * assumes field inputs are synchronous to clk.
 */
`timescale 1ns/1ps
module mrr_host (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [mrr_pkg::NUM_DEC-1:0] decTrigIn,
	input wire logic diTrigIn,
	input wire logic logicTrigIn,
	input wire logic extReleaseIn,
	input wire logic pccTripIn,
	input wire logic liveBusIn,
	input wire logic liveLineIn,
	input wire logic syncOkIn,
	input wire logic [15:0] freqIn,
	input wire logic [mrr_pkg::NUM_PH-1:0][15:0] vInstIn,
	input wire logic [mrr_pkg::NUM_PH-1:0][15:0] vAvgIn,
	mrr_link_if.host link
);
	logic [7:0] ctrl_q;
	logic [15:0] tBlk_q;
	logic [15:0] tStab_q;
	logic [31:0] fLim_q;
	logic [31:0] vLim_q;
	logic [1:0] cmd_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic wrEn;
	logic rdEn;
	logic mapped;

	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & ~penable & ~pwrite;
	assign mapped = (paddr <= mrr_pkg::OFS_CMD) && (paddr[1:0] == 2'b00);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= mrr_pkg::CTRL_RESET;
			tBlk_q <= mrr_pkg::T_REL_BLO_S_RESET;
			tStab_q <= mrr_pkg::T_STABLE_S_RESET;
			fLim_q <= {mrr_pkg::F_MAX_RESET, mrr_pkg::F_MIN_RESET};
			vLim_q <= {mrr_pkg::V_MAX_RESET, mrr_pkg::V_MIN_RESET};
			cmd_q <= 2'h0;
		end else if (ce) begin
			cmd_q <= 2'h0;
			if (wrEn) begin
				unique case (paddr)
					mrr_pkg::OFS_CTRL: ctrl_q <= pwdata[7:0];
					mrr_pkg::OFS_TBLK: tBlk_q <= pwdata[15:0];
					mrr_pkg::OFS_TSTAB: tStab_q <= pwdata[15:0];
					mrr_pkg::OFS_FLIM: fLim_q <= pwdata;
					mrr_pkg::OFS_VLIM: vLim_q <= pwdata;
					mrr_pkg::OFS_CMD: cmd_q <= pwdata[1:0];
					default: ;
				endcase
			end
		end
	end

	// read data and error are captured in the setup cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			if (psel & ~penable) begin
				pslverr_q <= ~mapped;
			end else begin
				pslverr_q <= 1'b0;
			end
			if (rdEn) begin
				unique case (paddr)
					mrr_pkg::OFS_CTRL: prdata_q <= {24'h000000, ctrl_q};
					mrr_pkg::OFS_TBLK: prdata_q <= {16'h0000, tBlk_q};
					mrr_pkg::OFS_TSTAB: prdata_q <= {16'h0000, tStab_q};
					mrr_pkg::OFS_FLIM: prdata_q <= fLim_q;
					mrr_pkg::OFS_VLIM: prdata_q <= vLim_q;
					mrr_pkg::OFS_STATUS: prdata_q <= {27'h0000000, link.state,
						link.windowOk, link.closePermit, link.release_};
					default: prdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q;

	// field inputs and settings handed over from flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link.decTrig <= '0;
			link.diTrig <= 1'b0;
			link.logicTrig <= 1'b0;
			link.scadaTrig <= 1'b0;
			link.extRelease <= 1'b0;
			link.pccTrip <= 1'b0;
			link.manualReset <= 1'b0;
			link.liveBus <= 1'b0;
			link.liveLine <= 1'b0;
			link.syncOk <= 1'b0;
			link.freq <= 16'h0000;
			link.vInst <= '0;
			link.vAvg <= '0;
		end else if (ce) begin
			link.decTrig <= decTrigIn;
			link.diTrig <= diTrigIn;
			link.logicTrig <= logicTrigIn;
			link.scadaTrig <= cmd_q[mrr_pkg::CMD_SCADA];
			link.extRelease <= extReleaseIn;
			link.pccTrip <= pccTripIn;
			link.manualReset <= cmd_q[mrr_pkg::CMD_MANUAL];
			link.liveBus <= liveBusIn;
			link.liveLine <= liveLineIn;
			link.syncOk <= syncOkIn;
			link.freq <= freqIn;
			link.vInst <= vInstIn;
			link.vAvg <= vAvgIn;
		end
	end

	assign link.relCond = ctrl_q[mrr_pkg::CTRL_COND_LSB +: 2];
	assign link.extEnable = ctrl_q[mrr_pkg::CTRL_EXT_EN];
	assign link.avgMethod = ctrl_q[mrr_pkg::CTRL_AVG];
	assign link.ovrEnable = ctrl_q[mrr_pkg::CTRL_OVR_LSB +: 3];
	assign link.syncBypass = ctrl_q[mrr_pkg::CTRL_BYPASS];
	assign link.tRelBlo = tBlk_q;
	assign link.tStable = tStab_q;
	assign link.fMin = fLim_q[15:0];
	assign link.fMax = fLim_q[mrr_pkg::LIM_MAX_LSB +: 16];
	assign link.vMin = vLim_q[15:0];
	assign link.vMax = vLim_q[mrr_pkg::LIM_MAX_LSB +: 16];
endmodule : mrr_host

// >>> shared/mrr_link_if.sv
/*
 * link between the controller end and the release logic end.
 * assumes both ends share clk; all signals are levels driven from flops.
 */
`timescale 1ns/1ps
interface mrr_link_if;
	logic [mrr_pkg::NUM_DEC-1:0] decTrig;
	logic diTrig;
	logic logicTrig;
	logic scadaTrig;
	logic extRelease;
	logic pccTrip;
	logic manualReset;
	logic liveBus;
	logic liveLine;
	logic syncOk;
	logic syncBypass;
	logic [1:0] relCond;
	logic extEnable;
	logic avgMethod;
	logic [2:0] ovrEnable;
	logic [15:0] tRelBlo;
	logic [15:0] tStable;
	logic [15:0] fMin;
	logic [15:0] fMax;
	logic [15:0] vMin;
	logic [15:0] vMax;
	logic [15:0] freq;
	logic [mrr_pkg::NUM_PH-1:0][15:0] vInst;
	logic [mrr_pkg::NUM_PH-1:0][15:0] vAvg;
	logic release_;
	logic closePermit;
	logic windowOk;
	logic [1:0] state;

	modport dev (input decTrig, diTrig, logicTrig, scadaTrig, extRelease, pccTrip,
		manualReset, liveBus, liveLine, syncOk, syncBypass, relCond, extEnable,
		avgMethod, ovrEnable, tRelBlo, tStable, fMin, fMax, vMin, vMax, freq, vInst,
		vAvg, output release_, closePermit, windowOk, state);
	modport host (output decTrig, diTrig, logicTrig, scadaTrig, extRelease, pccTrip,
		manualReset, liveBus, liveLine, syncOk, syncBypass, relCond, extEnable,
		avgMethod, ovrEnable, tRelBlo, tStable, fMin, fMax, vMin, vMax, freq, vInst,
		vAvg, input release_, closePermit, windowOk, state);
endinterface : mrr_link_if

// >>> shared/mrr_pkg.sv
/*
 * constants and types for the mains reconnection release block.
 * assumes a 25 MHz clock; voltages are in 0.01 % of nominal, frequency in 0.01 Hz.
 */
// Operation
// - override sync on enabled dead/live bus-line states
// - external bypass removes sync check dependency
// - six decoupling triggers plus input, logic, command
// - triggers ORed, any trigger starts block timer
// - block timer settable, default ten minutes
// - no release before block timer elapsed
// - voltage/frequency out of window restarts timer
// - release after quantities stable for settable time
// - selector: internal, external or both
// - both means internal AND external release
// - internal release checks three phase-phase voltages
// - external enable gates use of external signal
// - remote release must be wired to input
// - settable frequency and voltage window limits
// - averaged method uses one-minute average voltages
// - coupling-point trip needs manual reconnection; only a trip in release or manual state forces manual
// - high-voltage setting 47.5-51.5 Hz, five minutes
// - medium-voltage setting above 95 %, 50.05 Hz
package mrr_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int TICK_TIME_MS = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
	localparam int NUM_DEC = 6;
	localparam int NUM_PH = 3;
	localparam int VAL_W = 16;

	// register byte offsets of the controller
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TBLK = 8'h04;
	localparam logic [7:0] OFS_TSTAB = 8'h08;
	localparam logic [7:0] OFS_FLIM = 8'h0C;
	localparam logic [7:0] OFS_VLIM = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CMD = 8'h18;

	// control field positions
	localparam int CTRL_COND_LSB = 0;
	localparam int CTRL_EXT_EN = 2;
	localparam int CTRL_AVG = 3;
	localparam int CTRL_OVR_LSB = 4;
	localparam int CTRL_BYPASS = 7;
	localparam int CMD_MANUAL = 0;
	localparam int CMD_SCADA = 1;
	localparam int LIM_MAX_LSB = 16;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] T_REL_BLO_S_RESET = 16'h0258;
	localparam logic [15:0] T_STABLE_S_RESET = 16'h012C;
	localparam logic [15:0] F_MIN_RESET = 16'h128E;
	localparam logic [15:0] F_MAX_RESET = 16'h141E;
	localparam logic [15:0] V_MIN_RESET = 16'h251C;
	localparam logic [15:0] V_MAX_RESET = 16'h2AF8;

	typedef enum logic [1:0] {
		COND_INTERNAL = 2'b00,
		COND_EXTERNAL = 2'b01,
		COND_BOTH = 2'b10,
		COND_NONE = 2'b11
	} mrr_cond_t;

	typedef enum logic [1:0] {
		ST_BLOCK = 2'b00,
		ST_STABLE = 2'b01,
		ST_RELEASE = 2'b10,
		ST_MANUAL = 2'b11
	} mrr_state_t;
endpackage : mrr_pkg

// >>> tb/mrr_monitor.sv
/* link checker: release, close permit and manual state against link inputs.
 assumes one clock and ce held high by the bench. */
`timescale 1ns/1ps
module mrr_monitor (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [mrr_pkg::NUM_DEC-1:0] decTrig,
	input wire logic diTrig,
	input wire logic logicTrig,
	input wire logic scadaTrig,
	input wire logic extRelease,
	input wire logic pccTrip,
	input wire logic manualReset,
	input wire logic liveBus,
	input wire logic liveLine,
	input wire logic syncOk,
	input wire logic syncBypass,
	input wire logic [1:0] relCond,
	input wire logic extEnable,
	input wire logic [2:0] ovrEnable,
	input wire logic release_,
	input wire logic closePermit,
	input wire logic windowOk,
	input wire logic [1:0] state
);
	logic trig;
	logic ovrHit;
	assign trig = |decTrig | diTrig | logicTrig | scadaTrig;
	assign ovrHit = ovrEnable[0] & liveBus & ~liveLine | ovrEnable[1] & ~liveBus & liveLine
		| ovrEnable[2] & ~liveBus & ~liveLine;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_trig_drop: assert property (trig |=> !release_)
		else $error("release held after trigger");
	chk_rel_state: assert property (release_ |-> state == mrr_pkg::ST_RELEASE)
		else $error("release outside release state");
	chk_rel_entry: assert property ($rose(release_) |-> $past(state) == mrr_pkg::ST_STABLE)
		else $error("release not entered from stable");
	chk_cond_none: assert property ($rose(release_) |-> $past(relCond) != 2'b11)
		else $error("release with no condition");
	chk_ext_gate: assert property ($rose(release_)
		&& $past(relCond) inside {2'b01, 2'b10} |-> $past(extEnable && extRelease))
		else $error("release without external signal");
	chk_int_window: assert property ($rose(release_) && $past(relCond) != 2'b01 |->
		$past(windowOk))
		else $error("release with window bad");
	chk_close_gate: assert property (closePermit ==
		(release_ && $past(syncOk || syncBypass || ovrHit)))
		else $error("close permit mismatch");
	chk_pcc_manual: assert property ($past(pccTrip) && !$past(trig) &&
		$past(state) == mrr_pkg::ST_RELEASE |-> state == mrr_pkg::ST_MANUAL)
		else $error("coupling trip did not force manual");
	chk_man_exit: assert property ($past(manualReset) && !$past(pccTrip) &&
		$past(state) == mrr_pkg::ST_MANUAL |-> state == mrr_pkg::ST_BLOCK)
		else $error("manual reset did not return to block");
endmodule : mrr_monitor

// >>> tb/testbench.sv
/* self-checking bench: controller and release ends joined by the link.
 assumes a short timer tick and short block and stable times. */
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin nErrors++; \
	$display("Error %0t got %h exp %h", $time, g, e); end end
module testbench;
	localparam int TK = 4;
	localparam int TB = 3;
	localparam int TS = 2;
	localparam int LO = (TB + TS - 2) * TK;
	localparam int HI = (TB + TS + 1) * TK + 8;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic er, di, lg, ext, pcc, lb, ll, sok, rel, cp, blk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] dec;
	logic [15:0] freq;
	logic [2:0][15:0] vi, va;
	int nErrors = 0;
	int samplesChecked = 0;
	mrr_link_if link ();
	mrr_host mrr_host_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .decTrigIn(dec), .diTrigIn(di), .logicTrigIn(lg), .extReleaseIn(ext),
		.pccTripIn(pcc), .liveBusIn(lb), .liveLineIn(ll), .syncOkIn(sok), .freqIn(freq),
		.vInstIn(vi), .vAvgIn(va), .link(link));
	mrr_device #(.TickCycles(TK)) mrr_device_i (.clk(clk), .arst_n(arst_n), .ce(1'b1),
		.link(link), .releaseOut(rel), .closePermitOut(cp), .blockRunning(blk));
	mrr_monitor mrr_monitor_i (.clk(clk), .arst_n(arst_n), .decTrig(link.decTrig),
		.diTrig(link.diTrig), .logicTrig(link.logicTrig), .scadaTrig(link.scadaTrig),
		.extRelease(link.extRelease), .pccTrip(link.pccTrip), .manualReset(link.manualReset),
		.liveBus(link.liveBus), .liveLine(link.liveLine), .syncOk(link.syncOk),
		.syncBypass(link.syncBypass), .relCond(link.relCond), .extEnable(link.extEnable),
		.ovrEnable(link.ovrEnable), .release_(link.release_), .closePermit(link.closePermit),
		.windowOk(link.windowOk), .state(link.state));
	task automatic final_report();
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// values read here are those standing just before this edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		er = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK({er, rd}, {1'b0, e})
	endtask : rdChk
	task automatic waitRel();
		int n;
		n = 0;
		while (rel !== 1'b1 && n <= HI) begin
			@(negedge clk);
			n++;
		end
		`CHK(n >= LO && n <= HI, 1'b1)
	endtask : waitRel
	task automatic fire(input int k);
		@(posedge clk);
		if (k < 6) dec[k] <= 1'b1;
		else if (k == 6) di <= 1'b1;
		else lg <= 1'b1;
		@(posedge clk);
		dec <= 6'h00;
		di <= 1'b0;
		lg <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK(rel, 1'b0)
		@(negedge clk);
		`CHK(blk, 1'b1)
	endtask : fire
	task automatic quiet(input logic e);
		repeat (40) @(negedge clk);
		`CHK(rel, e)
		@(posedge clk);
	endtask : quiet
	task automatic t_regs();
		rdChk(mrr_pkg::OFS_CTRL, 32'h0000_0000);
		rdChk(mrr_pkg::OFS_TBLK, 32'h0000_0258);
		rdChk(mrr_pkg::OFS_TSTAB, 32'h0000_012C);
		rdChk(mrr_pkg::OFS_FLIM, 32'h141E_128E);
		rdChk(mrr_pkg::OFS_VLIM, 32'h2AF8_251C);
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, mrr_pkg::OFS_TBLK, 32'(TB));
		apb(1'b1, mrr_pkg::OFS_TSTAB, 32'(TS));
		$display("register test done");
	endtask : t_regs
	task automatic t_trig();
		for (int k = 0; k < 8; k++) begin
			fire(k);
			waitRel();
		end
		apb(1'b1, mrr_pkg::OFS_CMD, 32'h0000_0002);
		repeat (3) @(negedge clk);
		`CHK(rel, 1'b0)
		waitRel();
		fire(0);
		repeat (6) @(posedge clk);
		freq <= 16'h0FA0;
		repeat (2) @(posedge clk);
		freq <= 16'h1388;
		waitRel();
		$display("trigger test done");
	endtask : t_trig
	task automatic t_select();
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0001);
		ext <= 1'b1;
		fire(0);
		quiet(1'b0);
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0005);
		repeat (8) @(negedge clk);
		`CHK(rel, 1'b1)
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0006);
		vi <= {3{16'h2328}};
		fire(0);
		quiet(1'b0);
		vi <= {3{16'h2710}};
		waitRel();
		@(posedge clk);
		ext <= 1'b0;
		repeat (8) @(negedge clk);
		`CHK(rel, 1'b0)
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0007);
		ext <= 1'b1;
		fire(0);
		quiet(1'b0);
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0008);
		va <= {3{16'h2328}};
		fire(0);
		quiet(1'b0);
		va <= {3{16'h2710}};
		waitRel();
		$display("select test done");
	endtask : t_select
	task automatic t_limits();
		apb(1'b1, mrr_pkg::OFS_FLIM, 32'h138D_128E);
		freq <= 16'h1392;
		fire(0);
		quiet(1'b0);
		freq <= 16'h1388;
		waitRel();
		apb(1'b1, mrr_pkg::OFS_FLIM, 32'h141E_128E);
		freq <= 16'h1392;
		repeat (4) @(negedge clk);
		`CHK(rel, 1'b1)
		$display("limits test done");
	endtask : t_limits
	task automatic t_close();
		@(posedge clk);
		lb <= 1'b1;
		ll <= 1'b1;
		for (int o = 0; o < 3; o++) begin
			@(posedge clk);
			lb <= (o == 0);
			ll <= (o == 1);
			repeat (4) @(negedge clk);
			`CHK(cp, 1'b0)
			apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0008 | (32'h0000_0010 << o));
			repeat (4) @(negedge clk);
			`CHK(cp, 1'b1)
		end
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0008);
		sok <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK(cp, 1'b1)
		apb(1'b1, mrr_pkg::OFS_CTRL, 32'h0000_0088);
		sok <= 1'b0;
		lb <= 1'b1;
		ll <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK(cp, 1'b1)
		$display("close test done");
	endtask : t_close
	task automatic t_manual();
		@(posedge clk);
		pcc <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK(rel, 1'b0)
		@(posedge clk);
		pcc <= 1'b0;
		repeat (40) @(posedge clk);
		apb(1'b0, mrr_pkg::OFS_STATUS, 32'h0);
		`CHK(rd[4:0], 5'h1C)
		apb(1'b1, mrr_pkg::OFS_CMD, 32'h0000_0001);
		repeat (2) @(posedge clk);
		apb(1'b0, mrr_pkg::OFS_STATUS, 32'h0);
		`CHK(rd[4:0], 5'h04)
		$display("manual test done");
	endtask : t_manual
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{dec, di, lg, ext, pcc, lb, ll, sok} = '0;
		freq = 16'h1388;
		vi = {3{16'h2710}};
		va = {3{16'h2710}};
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_trig();
		t_select();
		t_limits();
		t_close();
		t_manual();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		final_report();
	end
endmodule : testbench
